// [logic/rpc_pkg.sv]
// Package: constants, register map and helpers of the rms and power path
package rpc_pkg;
   localparam int RPC_PHASES = 3;   // Phases A, B, C
   localparam int RPC_V_W = 16;     // Voltage sample width
   localparam int RPC_I_W = 24;     // Current sample width
   localparam int RPC_CAL_W = 12;   // Gain and offset width
   localparam int RPC_RMS_W = 24;   // Rms result width
   localparam int RPC_DP_W = 48;    // Internal datapath width
   localparam int RPC_EN_W = 41;    // Energy accumulator width
   localparam int RPC_EREG_W = 16;  // Visible energy bits
   localparam int RPC_RMS_DIV = 12; // Rms refresh divider
   localparam int RPC_ACC_DIV = 4;  // Energy accumulation divider
   localparam int RPC_K_VLPF = 2;   // Voltage low-pass shift
   localparam int RPC_K_MAV = 10;   // Mean absolute averaging shift
   localparam int RPC_K_ISQ = 10;   // Current square averaging shift
   localparam int RPC_K_PLPF = 8;   // Power low-pass shift
   localparam int RPC_VOLTAGE_RMS_RESULT_SH = 8;  // Sample to rms scale, 256
   localparam int RPC_VOS_SH = 6;   // Voltage offset weight, 64
   localparam int RPC_IOS_SH = 14;  // Current offset weight, 16384
   localparam int RPC_WOS_SH = 4;   // Power offset fraction, 1/16
   localparam int RPC_GAIN_SH = 12; // Gain denominator 2^12
   localparam logic [11:0] RPC_CAL_RST = 12'h000; // Calibration reset
   localparam int RPC_ADDR_W = 8;   // APB address width
   // Register kind sits in paddr[7:4], phase in paddr[3:2]
   localparam logic [3:0] RPC_K_IOS = 4'h0;  // Current rms offset
   localparam logic [3:0] RPC_K_VOS = 4'h1;  // Voltage rms offset
   localparam logic [3:0] RPC_K_VGN = 4'h2;  // Voltage rms gain
   localparam logic [3:0] RPC_K_WGN = 4'h3;  // Power gain
   localparam logic [3:0] RPC_K_WOS = 4'h4;  // Power offset
   localparam logic [3:0] RPC_K_CURRENT_RMS_RESULT = 4'h5; // Current rms result
   localparam logic [3:0] RPC_K_VOLTAGE_RMS_RESULT = 4'h6; // Voltage rms result
   localparam logic [3:0] RPC_K_ENGY = 4'h7; // Active energy
   localparam logic [3:0] RPC_K_APP = 4'h8;  // Apparent power
   // Square root engine states
   typedef enum logic [1:0] {
      RPC_SQ_IDLE = 2'b01,
      RPC_SQ_RUN = 2'b10
   } rpc_sq_t;

   // One-pole low-pass step
   function automatic logic signed [47:0] rpc_lpf(
      input logic signed [47:0] acc,
      input logic signed [47:0] x,
      input int k);
      rpc_lpf = acc + ((x - acc) >>> k);
   endfunction : rpc_lpf

   // Scale by one plus a signed 12-bit gain over 2^12
   function automatic logic signed [47:0] rpc_gain(
      input logic signed [47:0] x,
      input logic [11:0] g);
      logic signed [13:0] m;
      logic signed [61:0] p;
      m = $signed({{2{g[11]}}, g}) + 14'sh1000;
      p = x * m;
      rpc_gain = p[59:12];
   endfunction : rpc_gain

   // Saturate a 49-bit sum to 48 bits instead of wrapping
   function automatic logic signed [47:0] rpc_sat(input logic signed [48:0] x);
      if (x[48] != x[47]) begin
         rpc_sat = x[48] ? {1'b1, 47'h0} : {1'b0, {47{1'b1}}};
      end else begin
         rpc_sat = x[47:0];
      end
   endfunction : rpc_sat

   // Clip to an unsigned 24-bit result
   function automatic logic [23:0] rpc_clip(input logic signed [47:0] x);
      if (x[47]) begin
         rpc_clip = 24'h000000;
      end else if (|x[46:24]) begin
         rpc_clip = 24'hffffff;
      end else begin
         rpc_clip = x[23:0];
      end
   endfunction : rpc_clip
endpackage : rpc_pkg

// [logic/rpc_isqrt.sv]
// Sequential integer square root, two result bits per clock
`timescale 1ns/1ps
module rpc_isqrt #(
   parameter int RAD_W = 48
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request
   input wire logic start,
   input wire logic [RAD_W-1:0] radicand,
   // Answer
   output logic [RAD_W/2-1:0] root,
   output logic done
);
   import rpc_pkg::*;
   localparam int RW = RAD_W / 2;
   localparam int CW = $clog2(RW / 2);
   rpc_sq_t st_r;             // Engine state
   logic [RAD_W-1:0] rad_r;   // Radicand, consumed from the top
   logic [RW+1:0] rem_r;      // Partial remainder
   logic [RW-1:0] q_r;        // Partial root
   logic [CW-1:0] cnt_r;      // Cycle count within a root
   logic [2*RW+1:0] sq_nxt;   // Remainder and root after this cycle
   logic last;                // Final cycle of a root

   // One restoring step on one bit pair
   function automatic logic [2*RW+1:0] step(input logic [2*RW+1:0] rr,
                                            input logic [1:0] pr);
      logic [RW+3:0] rem;
      logic [RW+3:0] trial;
      logic [RW-1:0] q;
      rem = {rr[2*RW+1:RW], pr};
      q = rr[RW-1:0];
      trial = {2'b00, q, 2'b01};
      if (rem >= trial) begin
         rem = rem - trial;
         q = {q[RW-2:0], 1'b1};
      end else begin
         q = {q[RW-2:0], 1'b0};
      end
      step = {rem[RW+1:0], q};
   endfunction : step

   // Two steps per clock keep one root within twelve clocks
   always_comb begin
      sq_nxt = step(step({rem_r, q_r}, rad_r[RAD_W-1 -: 2]), rad_r[RAD_W-3 -: 2]);
      last = (st_r == RPC_SQ_RUN) && (cnt_r == CW'(RW / 2 - 1));
   end

   // Engine: a start in the final cycle chains straight on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= RPC_SQ_IDLE;
         rad_r <= '0;
         rem_r <= '0;
         q_r <= '0;
         cnt_r <= '0;
      end else if (start) begin
         st_r <= RPC_SQ_RUN;
         rad_r <= radicand;
         rem_r <= '0;
         q_r <= '0;
         cnt_r <= '0;
      end else begin
         case (st_r)
            RPC_SQ_RUN: begin
               {rem_r, q_r} <= sq_nxt;
               rad_r <= {rad_r[RAD_W-5:0], 4'h0};
               cnt_r <= cnt_r + 1'b1;
               if (last) begin
                  st_r <= RPC_SQ_IDLE;
               end
            end
            RPC_SQ_IDLE: begin
               st_r <= RPC_SQ_IDLE;
            end
            default: begin
               st_r <= RPC_SQ_IDLE;
            end
         endcase
      end
   end

   // Result register and completion pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         root <= '0;
         done <= 1'b0;
      end else begin
         done <= last;
         if (last) begin
            root <= sq_nxt[RW-1:0];
         end
      end
   end
endmodule : rpc_isqrt

// [logic/rpc_rms_power_path.sv]
// Three-phase rms, power and calibration datapath with APB registers
`timescale 1ns/1ps
module rpc_rms_power_path (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rpc_pkg::RPC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Waveform samples, one per clock
   input wire logic signed [rpc_pkg::RPC_V_W-1:0] volt_samp [rpc_pkg::RPC_PHASES],
   input wire logic signed [rpc_pkg::RPC_I_W-1:0] cur_samp [rpc_pkg::RPC_PHASES],
   // Refresh marker
   output logic rms_tick
);
   import rpc_pkg::*;

   // Map: byte address = kind * 0x10 + phase * 4, phases A to C as 0 to 2
   //   kind 0: current rms offset (rw)
   //   kind 1: voltage rms offset (rw)
   //   kind 2: voltage rms gain (rw)
   //   kind 3: power gain (rw)
   //   kind 4: power offset (rw)
   //   kind 5: current rms (ro)
   //   kind 6: voltage rms (ro)
   //   kind 7: active energy, top 16 bits (ro)
   //   kind 8: apparent power (ro)
   // Anything else, or a write to a result, answers with an error.
   // Datapath per phase, one sample pair per clock:
   //   voltage, gain, low-pass, mean absolute, plus offset, rms
   //   current, square, average, plus offset, clamp, root, rms
   //   low-passed voltage times current, plus offset, average, gain, energy
   // No sine form factor is applied, so a sine reads about ten
   // percent low until the voltage gain is trimmed.
   // Every average is a shift-based one-pole filter: cheap, but it
   // settles over thousands of clocks, so calibrate only after that.
   // Rms results refresh every twelve clocks, energy every fourth.

   // Calibration registers
   logic [11:0] ios_r [RPC_PHASES]; // Current rms offset
   logic [11:0] vos_r [RPC_PHASES]; // Voltage rms offset
   logic [11:0] vgn_r [RPC_PHASES]; // Voltage rms gain
   logic [11:0] wgn_r [RPC_PHASES]; // Power gain
   logic [11:0] wos_r [RPC_PHASES]; // Power offset

   // Filter state
   logic signed [47:0] vlp_r [RPC_PHASES];  // Voltage sample low-pass
   logic signed [47:0] mav_r [RPC_PHASES];  // Mean absolute voltage
   logic signed [47:0] isq_r [RPC_PHASES];  // Mean current square
   logic signed [47:0] pavg_r [RPC_PHASES]; // Power average, 1/16 units
   logic signed [40:0] en_r [RPC_PHASES];   // Energy accumulator

   // Results
   logic [23:0] voltage_rms_result_r [RPC_PHASES]; // Voltage rms
   logic [23:0] current_rms_result_w [RPC_PHASES]; // Current rms from root engines
   logic root_done [RPC_PHASES]; // Root engine finished a result
   logic [23:0] app_r [RPC_PHASES];  // Apparent power

   // Timebase
   logic [3:0] div_r;     // Rms divider count
   logic [1:0] acnt_r;    // Accumulation divider count
   logic tick_r;          // Rms refresh pulse
   logic acc_tick_r;      // Energy accumulation pulse

   // Combinational datapath terms
   logic signed [47:0] vg [RPC_PHASES];   // Gain-corrected voltage
   logic signed [47:0] icor [RPC_PHASES]; // Offset-corrected square
   logic [47:0] rad [RPC_PHASES];         // Root engine input
   logic signed [47:0] vcor [RPC_PHASES]; // Corrected voltage rms
   logic signed [47:0] prod [RPC_PHASES]; // Instantaneous power
   logic signed [47:0] pin [RPC_PHASES];  // Power plus offset
   logic signed [47:0] pg [RPC_PHASES];   // Gain-corrected power
   logic sq_neg [RPC_PHASES];             // Corrected square below zero

   // Bus decode
   logic [3:0] kind;     // Register kind
   logic [1:0] ph;       // Phase index
   logic hit;            // Mapped address
   logic rw_kind;        // Writable kind
   logic wr_en;          // Write strobe in access phase
   logic [31:0] rd_val;  // Read value for the decoded address
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // Per phase arithmetic; power offset sits in 1/16 multiplier units
   always_comb begin
      for (int p = 0; p < RPC_PHASES; p++) begin
         // Gain ahead of voltage low-pass; apparent power follows it
         vg[p] = rpc_gain(48'(volt_samp[p]), vgn_r[p]);
         // Offset correction on the squared current
         icor[p] = isq_r[p] + (48'(signed'(ios_r[p])) <<< RPC_IOS_SH);
         sq_neg[p] = icor[p][47];
         rad[p] = sq_neg[p] ? 48'h0 : icor[p];
         // Mean absolute value is already in rms units; add the offset
         vcor[p] = mav_r[p]
                   + (48'(signed'(vos_r[p])) <<< RPC_VOS_SH);
         prod[p] = 48'(signed'(vlp_r[p][RPC_V_W-1:0])) * 48'(cur_samp[p]);
         pin[p] = rpc_sat(49'(prod[p] <<< RPC_WOS_SH)
                          + 49'(signed'(wos_r[p])));
         pg[p] = rpc_sat(49'(rpc_gain(pavg_r[p] >>> RPC_WOS_SH, wgn_r[p])));
      end
   end

   // Rms divider: one refresh pulse every twelve clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 4'h0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == 4'(RPC_RMS_DIV - 1));
         if (div_r == 4'(RPC_RMS_DIV - 1)) begin
            div_r <= 4'h0;
         end else begin
            div_r <= div_r + 4'h1;
         end
      end
   end

   // Accumulation divider: energy is summed every fourth clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acnt_r <= 2'h0;
         acc_tick_r <= 1'b0;
      end else begin
         acnt_r <= acnt_r + 2'h1;
         acc_tick_r <= (acnt_r == 2'(RPC_ACC_DIV - 1));
      end
   end

   // Filters run every clock; the divider only paces the results
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            vlp_r[p] <= '0;
            mav_r[p] <= '0;
            isq_r[p] <= '0;
            pavg_r[p] <= '0;
         end
      end else begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            vlp_r[p] <= rpc_lpf(vlp_r[p], vg[p], RPC_K_VLPF);
            // Absolute value is averaged, not squared; scaling to rms units
            // first keeps the filter's dead band below four sample LSBs
            mav_r[p] <= rpc_lpf(mav_r[p],
                                (vlp_r[p][47] ? -vlp_r[p] : vlp_r[p]) <<< RPC_VOLTAGE_RMS_RESULT_SH,
                                RPC_K_MAV);
            isq_r[p] <= rpc_lpf(isq_r[p], 48'(cur_samp[p] * cur_samp[p]), RPC_K_ISQ);
            pavg_r[p] <= rpc_lpf(pavg_r[p], pin[p], RPC_K_PLPF);
         end
      end
   end

   // Two root bits per clock finish a root just as the next refresh
   // pulse starts the following one, so the engines never fall behind
   // One root engine per phase, restarted on every refresh pulse
   for (genvar g = 0; g < RPC_PHASES; g++) begin : g_root
      rpc_isqrt #(
         .RAD_W(RPC_DP_W)
      ) u_root (
         .pclk(pclk),
         .presetn(presetn),
         .start(tick_r),
         .radicand(rad[g]),
         .root(current_rms_result_w[g]),
         .done(root_done[g])
      );
   end

   // Voltage rms and apparent power are latched on the refresh pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            voltage_rms_result_r[p] <= '0;
            app_r[p] <= '0;
         end
      end else if (tick_r) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            voltage_rms_result_r[p] <= rpc_clip(vcor[p]);
            // Product of the two rms values, so voltage gain shows here too
            app_r[p] <= rpc_clip(48'((voltage_rms_result_r[p] * current_rms_result_w[p]) >> RPC_RMS_W));
         end
      end
   end

   // Software sees the top sixteen bits; the low bits carry the fraction
   // forward so that small powers still add up over time
   // Energy accumulates signed and wraps, as a meter register should
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            en_r[p] <= '0;
         end
      end else if (acc_tick_r) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            en_r[p] <= en_r[p] + 41'(pg[p]);
         end
      end
   end

   // Address decode; phase three and kinds above eight are unmapped
   always_comb begin
      kind = paddr[7:4];
      ph = paddr[3:2];
      hit = (paddr[1:0] == 2'h0) && (ph != 2'h3) && (kind <= RPC_K_APP);
      rw_kind = (kind <= RPC_K_WOS);
      wr_en = psel && penable && pwrite && hit && rw_kind;
   end

   // Read multiplexer; calibration fields and energy sign-extend, other results zero-extend
   always_comb begin
      rd_val = 32'h0;
      if (hit) begin
         case (kind)
            RPC_K_IOS: rd_val = 32'(signed'(ios_r[ph]));
            RPC_K_VOS: rd_val = 32'(signed'(vos_r[ph]));
            RPC_K_VGN: rd_val = 32'(signed'(vgn_r[ph]));
            RPC_K_WGN: rd_val = 32'(signed'(wgn_r[ph]));
            RPC_K_WOS: rd_val = 32'(signed'(wos_r[ph]));
            RPC_K_CURRENT_RMS_RESULT: rd_val = {8'h0, current_rms_result_w[ph]};
            RPC_K_VOLTAGE_RMS_RESULT: rd_val = {8'h0, voltage_rms_result_r[ph]};
            RPC_K_ENGY: rd_val = 32'(signed'(en_r[ph][40:25]));
            RPC_K_APP: rd_val = {8'h0, app_r[ph]};
            default: rd_val = 32'h0;
         endcase
      end
   end

   // Trade-off: no wait states, but a result that refreshes during the
   // access phase is returned at its value from the setup edge
   // APB answer: captured in setup, so access is zero wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= 1'b1;
         if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0 : rd_val;
            // Unmapped, or a write to a result register
            pslverr_r <= !hit || (pwrite && !rw_kind);
         end
      end
   end

   // Writes land at the access edge; upper data bits are ignored
   // Calibration writes; all clear to no correction at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < RPC_PHASES; p++) begin
            ios_r[p] <= RPC_CAL_RST;
            vos_r[p] <= RPC_CAL_RST;
            vgn_r[p] <= RPC_CAL_RST;
            wgn_r[p] <= RPC_CAL_RST;
            wos_r[p] <= RPC_CAL_RST;
         end
      end else if (wr_en) begin
         case (kind)
            RPC_K_IOS: ios_r[ph] <= pwdata[11:0];
            RPC_K_VOS: vos_r[ph] <= pwdata[11:0];
            RPC_K_VGN: vgn_r[ph] <= pwdata[11:0];
            RPC_K_WGN: wgn_r[ph] <= pwdata[11:0];
            RPC_K_WOS: wos_r[ph] <= pwdata[11:0];
            default: ios_r[0] <= ios_r[0];
         endcase
      end
   end

   // Outputs come straight from flip-flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rms_tick = tick_r;

   // Checks on datapath and bus; all sample on the rising edge and
   // stay off while reset is held
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   tick_period_a: assert property (tick_r |-> ##12 tick_r)
      else $error("refresh pulse not twelve clocks apart");
   tick_single_a: assert property (tick_r |=> !tick_r ##1 !tick_r)
      else $error("refresh pulse too wide");
   voltage_rms_result_hold_a: assert property (!tick_r |=> $stable(voltage_rms_result_r[0]))
      else $error("voltage rms changed between refreshes");
   voltage_rms_result_value_a: assert property (tick_r |=> voltage_rms_result_r[0] == rpc_clip($past(vcor[0])))
      else $error("voltage rms not offset corrected");
   sq_clamp_a: assert property (sq_neg[1] |-> rad[1] == 48'h0)
      else $error("negative square reached root engine");
   ios_apply_a: assert property (ios_r[0] == 12'h000 && !sq_neg[0] |-> rad[0] == isq_r[0])
      else $error("current offset applied when zero");
   vgain_unity_a: assert property (vgn_r[2] == 12'h000 |-> vg[2] == 48'(volt_samp[2]))
      else $error("voltage gain not unity at zero");
   wgain_unity_a: assert property (
      wgn_r[0] == 12'h000 |-> pg[0] == (pavg_r[0] >>> RPC_WOS_SH))
      else $error("power gain not unity at zero");
   energy_step_a: assert property (
      acc_tick_r |=> en_r[0] == $past(en_r[0]) + 41'($past(pg[0])))
      else $error("energy did not accumulate power");
   energy_hold_a: assert property (!acc_tick_r |=> $stable(en_r[0]))
      else $error("energy changed off accumulation pulse");
   mav_sign_a: assert property (mav_r[0] >= 0)
      else $error("mean absolute value went negative");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("access phase without ready");

   // Current path, apparent power, power offset, voltage gain and calibration hold
   app_value_a: assert property (tick_r |=> app_r[0] == rpc_clip(48'(
      ($past(voltage_rms_result_r[0]) * $past(current_rms_result_w[0])) >> RPC_RMS_W)))
      else $error("apparent power not the rms product");
   current_rms_result_src_a: assert property ($changed(current_rms_result_w[0]) |-> root_done[0])
      else $error("current rms changed without a finished root");
   current_rms_result_rate_a: assert property (root_done[1] |-> ##12 root_done[1])
      else $error("current rms not refreshed every twelve clocks");
   wos_zero_a: assert property (
      wos_r[0] == 12'h000 |-> pin[0] == (prod[0] <<< RPC_WOS_SH))
      else $error("power offset applied when zero");
   vgain_half_a: assert property (
      vgn_r[0] == 12'h800 |-> vg[0] == (48'(volt_samp[0]) >>> 1))
      else $error("voltage gain 0x800 did not halve");
   cal_hold_a: assert property (!wr_en |=> $stable(vgn_r[1]) && $stable(wgn_r[1]))
      else $error("calibration changed without a write");

   voltage_rms_result_upd_c: cover property (tick_r ##1 $changed(voltage_rms_result_r[0]));
   cal_wr_c: cover property (wr_en && kind == RPC_K_VGN);
   clamp_c: cover property (sq_neg[0] && tick_r);
   err_c: cover property (psel && penable && pslverr);
   app_upd_c: cover property (tick_r ##1 app_r[0] != 24'h0);
endmodule : rpc_rms_power_path

// [bench/rpc_rms_power_path_test.sv]
// Self-checking testbench of the three-phase rms, power and calibration path
`timescale 1ns/1ps
module rpc_rms_power_path_test;
   import rpc_pkg::*;
   localparam int VS = 16384; // Dc voltage sample
   localparam int CS = 1000; // Dc current sample
   // Calibration set for the measurement: kind by phase A, B, C
   localparam logic [11:0] CAL [5][3] = '{'{12'h000, 12'h7ff, 12'h800},
      '{12'h000, 12'h000, 12'h000}, '{12'h000, 12'h800, 12'h000},
      '{12'h000, 12'h000, 12'h800}, '{12'h000, 12'h000, 12'h000}};
   logic pclk; // Bus clock
   logic presetn; // Active-low reset
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rms_tick;
   logic signed [RPC_V_W-1:0] volt_samp [RPC_PHASES];
   logic signed [RPC_I_W-1:0] cur_samp [RPC_PHASES];
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0; // Free cycle count, used to reckon elapsed energy time
   logic [31:0] rd; // Data of the last read
   logic err; // Error flag of the last transfer

   rpc_rms_power_path u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .volt_samp(volt_samp), .cur_samp(cur_samp), .rms_tick(rms_tick));

   // Clock of 8 ns period
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) cyc <= cyc + 1;

   // Count a comparison and report a failed one
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   // Byte address of a register kind and phase
   function automatic logic [7:0] addr(input int k, input int ph);
      addr = {k[3:0], ph[1:0], 2'b00};
   endfunction : addr

   // One APB transfer, entered just after a rising edge; an idle edge follows
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Read data is taken only at the edge where ready is seen high
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, "bus answer missing");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   // Edges until the refresh marker is seen high
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rms_tick !== 1'b1 && n < 40);
   endtask : wait_tick

   // Every register reads zero after reset while samples stay zero
   task automatic test_reset;
      for (int k = 0; k < 9; k++) begin
         for (int p = 0; p < 3; p++) begin
            xfer(1'b0, addr(k, p), 32'h0);
            chk(rd === 32'h0 && err === 1'b0, "reset value");
         end
      end
      $display("test reset values done");
   endtask : test_reset

   // Unmapped places refuse access and read-only results refuse writes
   task automatic test_refused;
      xfer(1'b0, 8'h90, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped read");
      xfer(1'b0, 8'h01, 32'h0);
      chk(err === 1'b1, "misaligned read");
      xfer(1'b1, 8'h0c, 32'h0000_0123);
      chk(err === 1'b1, "phase field 3 write");
      xfer(1'b1, addr(6, 0), 32'h0000_0456);
      chk(err === 1'b1, "result write");
      xfer(1'b0, addr(6, 0), 32'h0);
      chk(rd === 32'h0 && err === 1'b0, "result kept");
      $display("test refused access done");
   endtask : test_refused

   // Both extreme codes read back sign-extended; upper write bits ignored
   task automatic test_cal_access;
      logic [11:0] w;
      for (int i = 0; i < 2; i++) begin
         w = i ? 12'h7ff : 12'h800;
         for (int k = 0; k < 5; k++) begin
            for (int p = 0; p < 3; p++) begin
               xfer(1'b1, addr(k, p), {20'ha5a5a, w});
               xfer(1'b0, addr(k, p), 32'h0);
               chk(rd === {{20{w[11]}}, w} && err === 1'b0, "readback");
            end
         end
      end
      $display("test calibration access done");
   endtask : test_cal_access

   // Refresh marker repeats every twelve clocks
   task automatic test_tick;
      int n;
      wait_tick(n);
      for (int i = 0; i < 3; i++) begin
         wait_tick(n);
         chk(n == 12, "refresh spacing");
      end
      $display("test refresh rate done");
   endtask : test_tick

   // Dc waveforms on all phases; each phase carries a different calibration
   task automatic test_measure;
      logic [31:0] va;
      logic signed [31:0] ea;
      logic signed [31:0] ec;
      longint ex;
      int t0;
      int n;
      for (int k = 0; k < 5; k++) begin
         for (int p = 0; p < 3; p++) begin
            xfer(1'b1, addr(k, p), {20'h0, CAL[k][p]});
         end
      end
      volt_samp <= '{16'sd16384, 16'sd16384, -16'sd16384};
      cur_samp <= '{24'sd1000, 24'sd1000, 24'sd1000};
      t0 = cyc;
      // Long wait lets the one-pole averages settle fully
      repeat (20000) @(posedge pclk);
      xfer(1'b0, addr(6, 0), 32'h0);
      va = rd;
      chk(rd[31:24] === 8'h0 && rd > 32'd3670016 && rd < 32'd4718592, "voltage_rms_result A");
      xfer(1'b0, addr(6, 1), 32'h0);
      chk(rd * 64 > va * 31 && rd * 64 < va * 33, "voltage_rms_result B half");
      xfer(1'b0, addr(6, 2), 32'h0);
      chk(rd * 64 > va * 63 && rd * 64 < va * 65, "voltage_rms_result C mean abs");
      xfer(1'b0, addr(5, 0), 32'h0);
      chk(rd > 32'd980 && rd < 32'd1020, "current_rms_result A");
      // Rms product over 2^24: 16384 * 256 * 1000 >> 24 is 250
      xfer(1'b0, addr(8, 0), 32'h0);
      chk(rd > 32'd245 && rd < 32'd255, "apparent A");
      xfer(1'b0, addr(5, 1), 32'h0);
      chk(rd > 32'd5760 && rd < 32'd5994, "current_rms_result B offset");
      xfer(1'b0, addr(5, 2), 32'h0);
      chk(rd === 32'h0, "current_rms_result C clamp");
      xfer(1'b0, addr(7, 0), 32'h0);
      ea = rd;
      ex = (longint'(cyc - t0) * VS * CS / 4) >>> 25;
      chk(ea * 20 > ex * 19 && ea * 20 < ex * 21, "energy A");
      xfer(1'b0, addr(7, 2), 32'h0);
      ec = rd;
      chk(rd[31:16] === {16{rd[15]}} && (2 * ec + ea) * 16 < ea
         && (2 * ec + ea) * 16 > -ea, "energy C gain");
      // Offset step shows after the next refresh
      xfer(1'b1, addr(1, 0), 32'h0000_0800);
      wait_tick(n);
      wait_tick(n);
      xfer(1'b0, addr(6, 0), 32'h0);
      chk(rd === va - 32'd131072, "voltage_rms_result offset");
      $display("test measurement done");
   endtask : test_measure

   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      volt_samp = '{default: '0};
      cur_samp = '{default: '0};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_reset;
      test_refused;
      test_cal_access;
      test_tick;
      test_measure;
      stop_test;
   end

   // Watchdog, well beyond the some 20400 cycles of the tests
   initial begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test;
   end
endmodule : rpc_rms_power_path_test
